// *** design/pab_consts.vh ***
/*
  byte offsets, field positions and reset values of the port a/b block.
  assumes inclusion by bare name from the design files.
*/
`ifndef PAB_CONSTS_VH
`define PAB_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PAB_OFS_PTA_LATCH 12'h000
`define PAB_OFS_PTA_DIR 12'h004
`define PAB_OFS_PTA_PUE 12'h008
`define PAB_OFS_PTB_LATCH 12'h00C
`define PAB_OFS_PTB_DIR 12'h010
`define PAB_OFS_KBI_EN 12'h014
`define PAB_OFS_SYSCFG 12'h018

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PAB_BIT_WAKE 6
`define PAB_BIT_CLKOUT 7
`define PAB_BIT_IN_ONLY 2
`define PAB_BIT_OSC_PIN 4
`define PAB_BIT_IRQ_EN 0
`define PAB_BIT_OSCMODE_LO 1
`define PAB_BIT_OSCMODE_HI 2

// ----------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------
`define PAB_RST_DIR 8'h00
`define PAB_RST_DIR_A 6'h00
`define PAB_RST_PUE 6'h00
`define PAB_RST_KBI 6'h00
`define PAB_RST_SYSCFG 3'h0
`define PAB_OSC_INTERNAL 2'h0
`define PAB_OSC_EXTERNAL 2'h1
`define PAB_OSC_RC 2'h2
`define PAB_OSC_XTAL 2'h3
`define PAB_RESP_OKAY 2'h0
`define PAB_RESP_SLVERR 2'h2

`endif

// *** design/pab_sync.v ***
/*
  two-flop synchroniser for a bus of pin levels.
  assumes asynchronous inputs and one clock aclk.
*/
`timescale 1ns/10ps
module pab_sync #(
  parameter WIDTH = 14
)(
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------
  // two stages, first read only by second
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// *** design/pab_gpio.v ***
/*
  port a / port b general-purpose i/o with an axi4-lite register slave.
  assumes aclk at 25 MHz, synchronous active-low aresetn, and pads that
  resolve the wire from pin_*_out and pin_*_oe outside this module.
*/
// Contract
// [RULE1] port a has six pins, each with latch, direction and pullup bit
// [RULE2] irq function enabled: port a bit 2 reads zero
// [RULE3] irq disabled: bit 2 reads pin; branch test sees constant one
// [RULE4] port a latch bits read/write, untouched by reset
// [RULE5] read-only bit shows wakeup request latch; writes ignored
// [RULE6] bit six has no pin, pullup or direction; only wakeup view
// [RULE7] direction one drives pin, zero releases; reset clears all
// [RULE8] read returns latch when output, synced pin level when input
// [RULE9] latch writes always land; input pin read stays the pin
// [RULE10] pullup on only while enable is one and direction is zero
// [RULE11] internal/rc mode: select drives oscillator clock on bit-four pin
// [RULE12] crystal/external mode: select has no effect, still read/write
// [RULE13] keyboard enable bits turn port a pins into interrupt inputs
// [RULE14] port b eight-bit latch read/write, untouched by reset
// [RULE15] port b direction register governs each port b pin
// [RULE16] software loads data before turning a pin to output
// [RULE17] input-only pin never driven; unimplemented bits read zero
// [RULE18] pin levels pass a two-flop synchroniser before use
`timescale 1ns/10ps
`include "pab_consts.vh"
module pab_gpio #(
  parameter A_W = 6,
  parameter B_W = 8
)(
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [A_W-1:0] pin_a_in,
  output reg [A_W-1:0] pin_a_out,
  output reg [A_W-1:0] pin_a_oe,
  output reg [A_W-1:0] pin_a_pullup,
  input wire [B_W-1:0] pin_b_in,
  output reg [B_W-1:0] pin_b_out,
  output reg [B_W-1:0] pin_b_oe,
  input wire wakeup_request,
  input wire undivided_osc_clock,
  output reg [A_W-1:0] keyboard_irq_lines,
  output reg branch_irq_level
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [A_W-1:0] port_a_latch_q;
  reg [A_W-1:0] port_a_direction_q;
  reg [A_W-1:0] port_a_pullup_enable_q;
  reg clock_out_select_q;
  reg [B_W-1:0] port_b_latch_q;
  reg [B_W-1:0] port_b_direction_q;
  reg [A_W-1:0] keyboard_irq_enables_q;
  reg [2:0] system_config_second_q;
  reg aw_held_q;
  reg [11:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [31:0] rdata_d;
  reg rd_hit_d;
  reg wr_hit;
  wire [A_W+B_W+1:0] sync_q;
  wire [A_W-1:0] pin_a_sync;
  wire [B_W-1:0] pin_b_sync;
  wire wake_sync;
  wire osc_sync;
  wire irq_enabled;
  wire [1:0] osc_mode;
  wire clk_on_pin;
  wire do_write;
  wire [11:0] wa;
  wire [7:0] a_merged;
  reg [A_W-1:0] a_read;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  pab_sync #(
    .WIDTH(A_W + B_W + 2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({undivided_osc_clock, wakeup_request, pin_b_in, pin_a_in}),
    .sync_out(sync_q)
  ); // [RULE18]

  assign pin_a_sync = sync_q[A_W-1:0];
  assign pin_b_sync = sync_q[A_W+B_W-1:A_W];
  assign wake_sync = sync_q[A_W+B_W];
  assign osc_sync = sync_q[A_W+B_W+1];
  assign irq_enabled = system_config_second_q[`PAB_BIT_IRQ_EN];
  assign osc_mode = system_config_second_q[`PAB_BIT_OSCMODE_HI:
    `PAB_BIT_OSCMODE_LO];
  assign clk_on_pin = clock_out_select_q &&
    ((osc_mode == `PAB_OSC_INTERNAL) ||
    (osc_mode == `PAB_OSC_RC)); // [RULE11] [RULE12]

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [7:0] merge_byte;
    input [7:0] old;
    input [7:0] nw;
    input strb;
    begin
      merge_byte = strb ? nw : old;
    end
  endfunction

  // ----------------------------------------------------------------
  // port a latch merge, bits above the six pins dropped
  // ----------------------------------------------------------------
  assign a_merged = merge_byte({{(8-A_W){1'b0}}, port_a_latch_q},
    w_data_q[7:0], w_strb_q[0]);

  // ----------------------------------------------------------------
  // port a read value
  // ----------------------------------------------------------------
  always @*
  begin
    a_read = (port_a_direction_q & port_a_latch_q) |
      (~port_a_direction_q & pin_a_sync); // [RULE8] [RULE9]
    a_read[`PAB_BIT_IN_ONLY] = irq_enabled ? 1'b0 :
      pin_a_sync[`PAB_BIT_IN_ONLY]; // [RULE2] [RULE3]
  end

  // ----------------------------------------------------------------
  // write channel acceptance
  // ----------------------------------------------------------------
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wa = aw_addr_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PAB_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid &&
        !s_axi_bvalid;
      s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid &&
        !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `PAB_RESP_OKAY : `PAB_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @*
  begin
    case (wa)
      `PAB_OFS_PTA_LATCH, `PAB_OFS_PTA_DIR, `PAB_OFS_PTA_PUE,
      `PAB_OFS_PTB_LATCH, `PAB_OFS_PTB_DIR, `PAB_OFS_KBI_EN,
      `PAB_OFS_SYSCFG: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // data latches, no reset
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (do_write && wa == `PAB_OFS_PTA_LATCH)
      port_a_latch_q <= a_merged[A_W-1:0]; // [RULE4] [RULE9] [RULE5]
    if (do_write && wa == `PAB_OFS_PTB_LATCH)
      port_b_latch_q <= merge_byte(port_b_latch_q, w_data_q[7:0],
        w_strb_q[0]); // [RULE14]
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_a_direction_q <= `PAB_RST_DIR_A; // [RULE7]
      port_a_pullup_enable_q <= `PAB_RST_PUE;
      clock_out_select_q <= 1'b0;
      port_b_direction_q <= `PAB_RST_DIR;
      keyboard_irq_enables_q <= `PAB_RST_KBI;
      system_config_second_q <= `PAB_RST_SYSCFG;
    end
    else if (do_write && w_strb_q[0])
    begin
      case (wa)
        `PAB_OFS_PTA_DIR:
          port_a_direction_q <= w_data_q[A_W-1:0]; // [RULE1] [RULE7]
        `PAB_OFS_PTA_PUE:
        begin
          port_a_pullup_enable_q <= w_data_q[A_W-1:0]; // [RULE1]
          clock_out_select_q <= w_data_q[`PAB_BIT_CLKOUT]; // [RULE12]
        end
        `PAB_OFS_PTB_DIR:
          port_b_direction_q <= w_data_q[B_W-1:0]; // [RULE15]
        `PAB_OFS_KBI_EN:
          keyboard_irq_enables_q <= w_data_q[A_W-1:0]; // [RULE13]
        `PAB_OFS_SYSCFG:
          system_config_second_q <= w_data_q[2:0];
        default:
          port_a_direction_q <= port_a_direction_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always @*
  begin
    rdata_d = 32'h00000000; // [RULE17]
    rd_hit_d = 1'b1;
    case (s_axi_araddr)
      `PAB_OFS_PTA_LATCH:
      begin
        rdata_d[A_W-1:0] = a_read;
        rdata_d[`PAB_BIT_WAKE] = wake_sync; // [RULE5] [RULE6]
      end
      `PAB_OFS_PTA_DIR: rdata_d[A_W-1:0] = port_a_direction_q;
      `PAB_OFS_PTA_PUE:
      begin
        rdata_d[A_W-1:0] = port_a_pullup_enable_q;
        rdata_d[`PAB_BIT_CLKOUT] = clock_out_select_q; // [RULE12]
      end
      `PAB_OFS_PTB_LATCH:
        rdata_d[B_W-1:0] = (port_b_direction_q & port_b_latch_q) |
          (~port_b_direction_q & pin_b_sync); // [RULE15]
      `PAB_OFS_PTB_DIR: rdata_d[B_W-1:0] = port_b_direction_q;
      `PAB_OFS_KBI_EN: rdata_d[A_W-1:0] = keyboard_irq_enables_q;
      `PAB_OFS_SYSCFG: rdata_d[2:0] = system_config_second_q;
      default: rd_hit_d = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PAB_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rd_hit_d ? `PAB_RESP_OKAY : `PAB_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_a_out <= {A_W{1'b0}};
      pin_a_oe <= {A_W{1'b0}};
      pin_a_pullup <= {A_W{1'b0}};
      pin_b_out <= {B_W{1'b0}};
      pin_b_oe <= {B_W{1'b0}};
      keyboard_irq_lines <= {A_W{1'b0}};
      branch_irq_level <= 1'b1;
    end
    else
    begin
      pin_a_out <= port_a_latch_q;
      pin_a_oe <= port_a_direction_q; // [RULE7]
      pin_a_oe[`PAB_BIT_IN_ONLY] <= 1'b0; // [RULE17]
      pin_a_pullup <= port_a_pullup_enable_q & ~port_a_direction_q; // [RULE10]
      if (clk_on_pin)
      begin
        pin_a_out[`PAB_BIT_OSC_PIN] <= osc_sync; // [RULE11]
        pin_a_oe[`PAB_BIT_OSC_PIN] <= 1'b1;
        pin_a_pullup[`PAB_BIT_OSC_PIN] <= 1'b0;
      end
      pin_b_out <= port_b_latch_q;
      pin_b_oe <= port_b_direction_q; // [RULE15]
      keyboard_irq_lines <= keyboard_irq_enables_q & pin_a_sync; // [RULE13]
      if (clk_on_pin)
        keyboard_irq_lines[`PAB_BIT_OSC_PIN] <= 1'b0;
      branch_irq_level <= irq_enabled ?
        pin_a_sync[`PAB_BIT_IN_ONLY] : 1'b1; // [RULE3]
    end
  end
endmodule

// *** tb/pab_checker.sv ***
/*
  port-level assertions for the port a/b block.
  assumes a bind onto pab_gpio and one clock aclk.
*/
`timescale 1ns/10ps
module pab_checker #(
  parameter A_W = 6,
  parameter B_W = 8
)(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [A_W-1:0] pin_a_oe,
  input wire [A_W-1:0] pin_a_pullup,
  input wire [B_W-1:0] pin_b_oe,
  input wire branch_irq_level
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_in_only_quiet: assert property (!pin_a_oe[2])
    else $error("input-only pin driven");
  a_pullup_on_input: assert property (
    (pin_a_pullup & pin_a_oe) == 0)
    else $error("pullup on driven pin");
  a_reset_inputs: assert property ($rose(aresetn) |->
    pin_a_oe == 0 && pin_b_oe == 0)
    else $error("pins driven after reset");
  a_branch_idle: assert property ($rose(aresetn) |->
    branch_irq_level)
    else $error("branch level low after reset");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
endmodule
bind pab_gpio pab_checker #(.A_W(A_W), .B_W(B_W)) pab_checker_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .pin_a_oe(pin_a_oe), .pin_a_pullup(pin_a_pullup), .pin_b_oe(pin_b_oe),
  .branch_irq_level(branch_irq_level));

// *** tb/pab_pads.sv ***
/*
  pad and board model: resolves each pin from device drive and board level.
  assumes the board always drives pins that the device releases.
*/
`timescale 1ns/10ps
module pab_pads(
  input wire [5:0] a_out,
  input wire [5:0] a_oe,
  input wire [5:0] a_ext,
  output wire [5:0] a_in,
  input wire [7:0] b_out,
  input wire [7:0] b_oe,
  input wire [7:0] b_ext,
  output wire [7:0] b_in
);
  assign a_in = (a_oe & a_out) | (~a_oe & a_ext);
  assign b_in = (b_oe & b_out) | (~b_oe & b_ext);
endmodule

// *** tb/tb_top.sv ***
/*
  self-checking bench of the port a/b block with an axi4-lite master.
  assumes pab_gpio, pab_pads and pab_checker are compiled alongside.
*/
`timescale 1ns/10ps
`include "pab_consts.vh"
module tb_top;
  reg aclk = 0;
  reg aresetn = 0;
  reg [11:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, d, seed = 32'h1F6C8BAD;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [5:0] ext_a = 0, la, da, pa;
  reg [7:0] ext_b = 0, lb, db;
  reg wake = 0, osc = 0, on;
  reg [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, br;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] a_in, a_out, a_oe, a_pu, kbd;
  wire [7:0] b_in, b_out, b_oe;
  integer error_cnt = 0, num_checks = 0, i;
  always #20 aclk = ~aclk;
  pab_gpio pab_gpio_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_a_in(a_in), .pin_a_out(a_out),
    .pin_a_oe(a_oe), .pin_a_pullup(a_pu), .pin_b_in(b_in),
    .pin_b_out(b_out), .pin_b_oe(b_oe), .wakeup_request(wake),
    .undivided_osc_clock(osc), .keyboard_irq_lines(kbd),
    .branch_irq_level(br));
  pab_pads pab_pads_i (.a_out(a_out), .a_oe(a_oe), .a_ext(ext_a),
    .a_in(a_in), .b_out(b_out), .b_oe(b_oe), .b_ext(ext_b), .b_in(b_in));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed;
  endfunction
  function [7:0] exp_a(input [5:0] l, input [5:0] dir, input irq);
    reg [5:0] v;
    begin
      v = (dir & l) | (~dir & ext_a);
      v[2] = irq ? 1'b0 : ext_a[2];
      exp_a = {1'b0, wake, v};
    end
  endfunction
  task chk(input string nm, input [7:0] s, input [7:0] e);
    num_checks = num_checks + 1;
    if (s !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input [11:0] a, input [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    @(posedge aclk);
    while (!bvalid)
    begin
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      @(posedge aclk);
    end
    r = bresp;
    bready <= 0;
  endtask
  task rd(input [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    @(posedge aclk);
    while (!rvalid)
    begin
      if (arready) arvalid <= 0;
      @(posedge aclk);
    end
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #800000;
    error_cnt = error_cnt + 1;
    results;
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(`PAB_OFS_PTA_DIR);
    chk("dir a", d[7:0], 8'h00);
    rd(`PAB_OFS_PTA_PUE);
    chk("pue a", d[7:0], 8'h00);
    rd(`PAB_OFS_PTB_DIR);
    chk("dir b", d[7:0], 8'h00);
    for (i = 0; i < 24; i = i + 1)
    begin
      d = xs();
      {lb, pa, da, la} = {d[31:24], d[21:16], d[13:8], d[5:0]};
      d = xs();
      db = d[7:0];
      ext_a <= d[13:8];
      ext_b <= d[23:16];
      wake <= d[24];
      wr(`PAB_OFS_PTA_LATCH, {24'h0, 2'b11, la});
      chk("wresp", {6'h0, r}, {6'h0, `PAB_RESP_OKAY});
      wr(`PAB_OFS_PTA_DIR, {26'h0, da});
      wr(`PAB_OFS_PTA_PUE, {26'h0, pa});
      wr(`PAB_OFS_PTB_LATCH, {24'h0, lb});
      wr(`PAB_OFS_PTB_DIR, {24'h0, db});
      repeat (4) @(posedge aclk);
      rd(`PAB_OFS_PTA_LATCH);
      chk("port a", d[7:0], exp_a(la, da, 1'b0));
      chk("rresp", {6'h0, r}, {6'h0, `PAB_RESP_OKAY});
      rd(`PAB_OFS_PTB_LATCH);
      chk("port b", d[7:0], (db & lb) | (~db & ext_b));
      chk("oe a", {2'h0, a_oe}, {2'h0, da & 6'h3B});
      chk("out a", {2'h0, a_out}, {2'h0, la});
      chk("pullup a", {2'h0, a_pu}, {2'h0, pa & ~da});
      chk("oe b", b_oe, db);
      chk("out b", b_out, lb);
    end
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    wr(`PAB_OFS_PTA_DIR, 32'h3F);
    repeat (4) @(posedge aclk);
    rd(`PAB_OFS_PTA_LATCH);
    chk("kept a", d[7:0], exp_a(la, 6'h3F, 1'b0));
    wr(`PAB_OFS_PTB_DIR, 32'hFF);
    rd(`PAB_OFS_PTB_LATCH);
    chk("kept b", d[7:0], lb);
    wr(`PAB_OFS_SYSCFG, 32'h1);
    ext_a <= 6'h04;
    repeat (4) @(posedge aclk);
    rd(`PAB_OFS_PTA_LATCH);
    chk("irq bit", d[7:0], exp_a(la, 6'h3F, 1'b1));
    chk("branch hi", {7'h0, br}, 8'h01);
    ext_a <= 6'h00;
    repeat (4) @(posedge aclk);
    chk("branch lo", {7'h0, br}, 8'h00);
    wr(`PAB_OFS_SYSCFG, 32'h0);
    repeat (4) @(posedge aclk);
    chk("branch off", {7'h0, br}, 8'h01);
    ext_a <= 6'h04;
    repeat (4) @(posedge aclk);
    rd(`PAB_OFS_PTA_LATCH);
    chk("pin bit", d[7:0], exp_a(la, 6'h3F, 1'b0));
    wr(`PAB_OFS_PTA_DIR, 32'h0);
    wr(`PAB_OFS_PTA_PUE, 32'h90);
    for (i = 0; i < 4; i = i + 1)
    begin
      on = (i == 0 || i == 2);
      wr(`PAB_OFS_SYSCFG, i << 1);
      osc <= 1;
      repeat (4) @(posedge aclk);
      chk("clk hi", {7'h0, a_out[4]}, {7'h0, on | la[4]});
      chk("oe4", {7'h0, a_oe[4]}, {7'h0, on});
      osc <= 0;
      repeat (4) @(posedge aclk);
      chk("clk lo", {7'h0, a_out[4]}, {7'h0, !on & la[4]});
      chk("pu4", {7'h0, a_pu[4]}, {7'h0, !on});
    end
    rd(`PAB_OFS_PTA_PUE);
    chk("select", d[7:0], 8'h90);
    d = xs();
    ext_a <= d[5:0];
    wr(`PAB_OFS_KBI_EN, 32'h2D);
    repeat (4) @(posedge aclk);
    chk("kbd", {2'h0, kbd}, {2'h0, 6'h2D & ext_a});
    wr(12'h100, 32'hFF);
    chk("wr err", {6'h0, r}, {6'h0, `PAB_RESP_SLVERR});
    rd(12'h100);
    chk("rd err", {6'h0, r}, {6'h0, `PAB_RESP_SLVERR});
    chk("rd zero", d[7:0], 8'h00);
    results;
  end
endmodule
